// ==== inc/lts_defines.svh ====
// constants for the dual lookup-table tone synthesiser
// assumes a 10 MHz aclk; included by the package and the synthesiser design file
`ifndef LTS_DEFINES_SVH
`define LTS_DEFINES_SVH

// timing
`define LTS_CLK_HZ 10_000_000
`define LTS_SAMPLE_HZ 200_000
`define LTS_SAMPLE_DIV (`LTS_CLK_HZ / `LTS_SAMPLE_HZ)

// sequence generator
`define LTS_ACC_W 24
`define LTS_SEQ_W 13
`define LTS_SAMPLE_W 8
`define LTS_LEVEL_W 8
`define LTS_FREQ_MIN_HZ 20
`define LTS_FREQ_MAX_HZ 20_000
`define LTS_INC_MIN 24'((64'(`LTS_FREQ_MIN_HZ) << `LTS_ACC_W) / 64'(`LTS_SAMPLE_HZ))
`define LTS_INC_MAX 24'((64'(`LTS_FREQ_MAX_HZ) << `LTS_ACC_W) / 64'(`LTS_SAMPLE_HZ))

// register byte offsets
`define LTS_OFF_CTRL 8'h00
`define LTS_OFF_FREQ1 8'h04
`define LTS_OFF_FREQ2 8'h08
`define LTS_OFF_LEVEL1 8'h0C
`define LTS_OFF_LEVEL2 8'h10
`define LTS_OFF_STATUS 8'h14
`define LTS_OFF_SAMPLE 8'h18

// control field positions
`define LTS_CTRL_SHAPE1 0
`define LTS_CTRL_SHAPE2 1
`define LTS_CTRL_GATE_EN 2
`define LTS_CTRL_RUN 3

// status field positions
`define LTS_STAT_SEQ1_LSB 0
`define LTS_STAT_SEQ2_LSB 13
`define LTS_STAT_GATE_BIT 26
`define LTS_STAT_STALL 27

// reset values (1 kHz tone, full level)
`define LTS_CTRL_RST 4'h0
`define LTS_FREQ_RST 24'h01_47AE
`define LTS_LEVEL_RST 8'hFF

// axi responses
`define LTS_RESP_OKAY 2'h0
`define LTS_RESP_SLVERR 2'h2

`endif

// ==== inc/lts_pkg.sv ====
// types shared by the tone synthesiser and its bench
// assumes lts_defines.svh is on the include path
`include "lts_defines.svh"

package lts_pkg;

    typedef logic [`LTS_SAMPLE_W-1:0] lts_sample_t;

    // one output step: both generators' samples
    typedef struct packed {
        lts_sample_t gen2;
        lts_sample_t gen1;
    } lts_pair_s;

    typedef struct packed {
        logic run;
        logic gate_en;
        logic shape2;
        logic shape1;
    } lts_ctrl_s;

endpackage

// ==== design/lts_pair_fifo.sv ====
// small first-in first-out buffer with valid/ready on both sides
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module lts_pair_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [CW-1:0] count, next_count;
    logic push, pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign in_ready = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + CW'(1);
        end else if (pop && !push) begin
            next_count = count - CW'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule

`default_nettype wire

// ==== design/lts_tone_synth.sv ====
// dual lookup-table tone synthesiser with data-gated generator two
// assumes a 10 MHz aclk, an axi4-lite master and a sink on the sample stream
// How it works
// - each generator latches a host frequency word and repeats at that rate
// - a 13-bit sequence word addresses the lookup table every step
// - the table returns an 8-bit sample of the chosen shape each step
// - sine and square tables; each generator picks its shape alone
// - frequency word spans 20 Hz to 20 kHz, clamped to that range
// - a per-generator level code scales the sample in proportion
// - gate flop drives generator two's top address bit: full or no output
// - serial data on the gate flop input becomes tone bursts
// - with gating off the top address bit is the plain sequence bit
// - both generators share one design; gating leaves generator one alone and doubles generator two's pitch
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lts_defines.svh"

module lts_tone_synth #(
    parameter int ADDR_W = 8,
    parameter int BUF_DEPTH = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // serial gating data pin and the resulting address bit
    input wire logic gate_flop_data_input,
    output logic gate_flop_output,
    // sample stream toward the converters
    output logic out_valid,
    input wire logic out_ready,
    output lts_pkg::lts_pair_s out_data
);
    import lts_pkg::*;

    localparam int DIV_W = $clog2(`LTS_SAMPLE_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(`LTS_SAMPLE_DIV - 1);

    // quarter-wave sine magnitudes, 16 points
    localparam logic [6:0] SINE_Q [16] = '{
        7'd6, 7'd19, 7'd31, 7'd43, 7'd54, 7'd65, 7'd76, 7'd85,
        7'd94, 7'd102, 7'd109, 7'd115, 7'd120, 7'd123, 7'd126, 7'd127
    };

    // register state
    lts_ctrl_s ctrl, next_ctrl;
    logic [`LTS_ACC_W-1:0] inc [2];
    logic [`LTS_ACC_W-1:0] next_inc [2];
    logic [`LTS_LEVEL_W-1:0] level [2];
    logic [`LTS_LEVEL_W-1:0] next_level [2];
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;

    // read channel state
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // generator state
    logic [`LTS_ACC_W-1:0] acc [2];
    logic [`LTS_ACC_W-1:0] next_acc [2];
    logic [DIV_W-1:0] div_cnt, next_div_cnt;
    logic sync1, sync2, next_sync1, next_sync2;
    logic gate_q, next_gate_q;
    lts_pair_s last_pair, next_last_pair;

    // combinational
    logic [`LTS_SEQ_W-1:0] seq [2];
    logic [`LTS_SEQ_W-1:0] table_addr2;
    lts_pair_s step_pair;
    logic step, buf_in_ready, div_done;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            old[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
        merge = old;
    endfunction

    function automatic logic [`LTS_ACC_W-1:0] clamp_inc(input logic [31:0] v);
        if (v < 32'(`LTS_INC_MIN)) begin
            clamp_inc = `LTS_INC_MIN;
        end else if (v > 32'(`LTS_INC_MAX)) begin
            clamp_inc = `LTS_INC_MAX;
        end else begin
            clamp_inc = v[`LTS_ACC_W-1:0];
        end
    endfunction

    function automatic lts_sample_t lookup(input logic [`LTS_SEQ_W-1:0] a,
                                           input logic square, input logic gated);
        logic half;
        logic quart;
        logic [3:0] idx;
        logic [6:0] mag;
        half = gated ? a[11] : a[12];
        quart = gated ? a[10] : a[11];
        idx = gated ? a[9:6] : a[10:7];
        mag = SINE_Q[quart ? ~idx : idx];
        if (square) begin
            lookup = half ? 8'h01 : 8'hFF;
        end else begin
            lookup = half ? 8'(8'h80 - {1'b0, mag}) : 8'(8'h80 + {1'b0, mag});
        end
        if (gated && !a[12]) begin
            lookup = 8'h80;
        end
    endfunction

    function automatic lts_sample_t scale(input lts_sample_t s,
                                          input logic [`LTS_LEVEL_W-1:0] lvl);
        logic signed [8:0] dev;
        logic signed [17:0] prod;
        dev = $signed({1'b0, s}) - 9'sd128;
        prod = dev * $signed({1'b0, lvl});
        scale = 8'(prod[15:8] + 8'h80);
    endfunction

    // 13-bit word from the accumulator top
    assign seq[0] = acc[0][`LTS_ACC_W-1 -: `LTS_SEQ_W];
    assign seq[1] = acc[1][`LTS_ACC_W-1 -: `LTS_SEQ_W];

    assign gate_flop_output = ctrl.gate_en ? gate_q : seq[1][12];
    assign table_addr2 = {gate_flop_output, seq[1][11:0]};

    // same lookup for both, gating only on two
    assign step_pair.gen1 = scale(lookup(seq[0], ctrl.shape1, 1'b0), level[0]);
    assign step_pair.gen2 = scale(lookup(table_addr2, ctrl.shape2, ctrl.gate_en), level[1]);

    // a full buffer holds the step, so no sample is dropped
    assign div_done = (div_cnt == DIV_LAST);
    assign step = ctrl.run & div_done & buf_in_ready;

    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;

    // register write path
    always_comb begin
        next_ctrl = ctrl;
        next_inc = inc;
        next_level = level;
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `LTS_RESP_OKAY;
            unique case (aw_addr)
                ADDR_W'(`LTS_OFF_CTRL):
                    next_ctrl = 4'(merge(32'(ctrl), w_data, w_strb));
                ADDR_W'(`LTS_OFF_FREQ1):
                    next_inc[0] = clamp_inc(merge(32'(inc[0]), w_data, w_strb));
                ADDR_W'(`LTS_OFF_FREQ2):
                    next_inc[1] = clamp_inc(merge(32'(inc[1]), w_data, w_strb));
                ADDR_W'(`LTS_OFF_LEVEL1):
                    next_level[0] = 8'(merge(32'(level[0]), w_data, w_strb));
                ADDR_W'(`LTS_OFF_LEVEL2):
                    next_level[1] = 8'(merge(32'(level[1]), w_data, w_strb));
                ADDR_W'(`LTS_OFF_STATUS), ADDR_W'(`LTS_OFF_SAMPLE): begin
                    // read-only, write ignored
                end
                default: next_bresp = `LTS_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `LTS_CTRL_RST;
            inc[0] <= `LTS_FREQ_RST;
            inc[1] <= `LTS_FREQ_RST;
            level[0] <= `LTS_LEVEL_RST;
            level[1] <= `LTS_LEVEL_RST;
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `LTS_RESP_OKAY;
        end else begin
            ctrl <= next_ctrl;
            inc <= next_inc;
            level <= next_level;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    // register read path
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = `LTS_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (araddr)
                ADDR_W'(`LTS_OFF_CTRL): next_rdata = 32'(ctrl);
                ADDR_W'(`LTS_OFF_FREQ1): next_rdata = 32'(inc[0]);
                ADDR_W'(`LTS_OFF_FREQ2): next_rdata = 32'(inc[1]);
                ADDR_W'(`LTS_OFF_LEVEL1): next_rdata = 32'(level[0]);
                ADDR_W'(`LTS_OFF_LEVEL2): next_rdata = 32'(level[1]);
                ADDR_W'(`LTS_OFF_STATUS): begin
                    next_rdata[`LTS_STAT_SEQ1_LSB +: `LTS_SEQ_W] = seq[0];
                    next_rdata[`LTS_STAT_SEQ2_LSB +: `LTS_SEQ_W] = seq[1];
                    next_rdata[`LTS_STAT_GATE_BIT] = gate_flop_output;
                    next_rdata[`LTS_STAT_STALL] = !buf_in_ready;
                end
                ADDR_W'(`LTS_OFF_SAMPLE): next_rdata = 32'(last_pair);
                default: next_rresp = `LTS_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `LTS_RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // sequence generators, divider and gate flop
    always_comb begin
        next_sync1 = gate_flop_data_input;
        next_sync2 = sync1;
        next_gate_q = gate_q;
        next_acc = acc;
        next_last_pair = last_pair;
        next_div_cnt = div_cnt;
        if (!div_done) begin
            next_div_cnt = div_cnt + DIV_W'(1);
        end else if (step || !ctrl.run) begin
            next_div_cnt = '0;
        end
        if (step) begin
            for (int g = 0; g < 2; g++) begin
                next_acc[g] = acc[g] + inc[g];
            end
            next_gate_q = sync2;
            next_last_pair = step_pair;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc[0] <= '0;
            acc[1] <= '0;
            div_cnt <= '0;
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            gate_q <= 1'b0;
            last_pair <= '0;
        end else begin
            acc <= next_acc;
            div_cnt <= next_div_cnt;
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            gate_q <= next_gate_q;
            last_pair <= next_last_pair;
        end
    end

    lts_pair_fifo #(
        .WIDTH($bits(lts_pair_s)),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(step),
        .in_ready(buf_in_ready),
        .in_data(step_pair),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

endmodule

`default_nettype wire

// ==== bench/lts_tone_synth_sva.sv ====
// port checks for the dual tone synthesiser
// assumes one aclk domain and the synchronous active-low aresetn
`timescale 1ns/1ps
`default_nettype none

module lts_tone_synth_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // sample stream
    input wire logic out_valid,
    input wire logic out_ready,
    input wire lts_pkg::lts_pair_s out_data
);
    import lts_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_b_block;
        bvalid |-> !awready && !wready;
    endproperty
    a_b_block: assert property (p_b_block) else $error("write taken under response");
    property p_w_resp;
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
    endproperty
    a_w_resp: assert property (p_w_resp) else $error("write response late");
    property p_b_clear;
        bvalid && bready |=> !bvalid;
    endproperty
    a_b_clear: assert property (p_b_clear) else $error("write response repeated");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data changed");
    property p_r_lat;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_r_clear;
        rvalid && rready |=> !rvalid;
    endproperty
    a_r_clear: assert property (p_r_clear) else $error("read answer repeated");
    property p_o_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_data);
    endproperty
    a_o_hold: assert property (p_o_hold) else $error("sample lost in stall");

    c_stall: cover property ((out_valid && !out_ready) [*8]);
    c_pop: cover property (out_valid && out_ready);
    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready);
endmodule

bind lts_tone_synth lts_tone_synth_chk lts_tone_synth_chk_i (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data)
);

`default_nettype wire

// ==== bench/lts_sink_model.sv ====
// converter-side sink for the sample stream, stalls at random
// assumes the bench seeds the generator and may force a long stall
`timescale 1ns/1ps
`default_nettype none

module lts_sink_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // long stall request
    input wire logic hold,
    // sample stream
    input wire logic out_valid,
    output logic out_ready,
    input wire lts_pkg::lts_pair_s out_data
);
    import lts_pkg::*;
    lts_pair_s got[$];

    // a real converter may pause, so ready drops one cycle in four
    always @(posedge aclk) begin
        if (out_valid && out_ready) begin
            got.push_back(out_data);
        end
        out_ready <= aresetn && !hold && ($urandom_range(3) != 0);
    end
endmodule

`default_nettype wire

// ==== bench/lts_tone_synth_tb.sv ====
// self-checking bench for the dual tone synthesiser
// assumes the sink model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "lts_defines.svh"

module lts_tone_synth_tb;
    import lts_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata, d;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, out_valid, out_ready, gate_out;
    logic pin = 1'h0, hold = 1'h0, sq1 = 1'h1;
    lts_pair_s out_data, last_p;
    logic [23:0] inc1, inc2, acc1 = 24'h00_0000, acc2 = 24'h00_0000;
    logic [7:0] lv1, lv2;
    logic [7:0] offs [5] = '{`LTS_OFF_CTRL, `LTS_OFF_FREQ1, `LTS_OFF_FREQ2,
                             `LTS_OFF_LEVEL1, `LTS_OFF_LEVEL2};
    logic [31:0] rsts [5] = '{32'h0000_0000, 32'h0001_47AE, 32'h0001_47AE,
                              32'h0000_00FF, 32'h0000_00FF};
    int num_errors = 0, num_checks = 0;

    always #50 aclk = ~aclk;

    lts_tone_synth lts_tone_synth_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .gate_flop_data_input(pin),
        .gate_flop_output(gate_out), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data)
    );
    lts_sink_model lts_sink_model_i (
        .aclk(aclk), .aresetn(aresetn), .hold(hold), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        fork
            begin do @(posedge aclk); while (!awready); awvalid <= 1'h0; end
            begin do @(posedge aclk); while (!wready); wvalid <= 1'h0; end
        join
        do @(posedge aclk); while (!bvalid);
        rs = bresp;
        bready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'h0;
        @(posedge aclk);
    endtask

    // level applied to a full-scale square sample
    function automatic logic [7:0] sq(input logic [23:0] acc, input logic [7:0] lv);
        int s;
        s = (acc[23] ? -127 : 127) * int'(lv);
        return 8'(128 + (s >>> 8));
    endfunction

    function automatic logic [23:0] clamp(input logic [23:0] v);
        return (v < `LTS_INC_MIN) ? `LTS_INC_MIN : (v > `LTS_INC_MAX) ? `LTS_INC_MAX : v;
    endfunction

    // g: 0 gen2 square, 1 gated silent, 2 gated on, 3 settling
    task automatic take(input int n, input int g);
        lts_pair_s p;
        repeat (n) begin
            while (lts_sink_model_i.got.size() == 0) @(posedge aclk);
            p = lts_sink_model_i.got.pop_front();
            last_p = p;
            if (sq1) chk(p.gen1, sq(acc1, lv1));
            if (!sq1) chk(acc1[23] ? p.gen1 <= 8'h80 : p.gen1 >= 8'h80, 1'h1);
            if (g == 0) chk(p.gen2, sq(acc2, lv2));
            if (g == 1) chk(p.gen2, 8'h80);
            if (g == 2) chk(p.gen2 != 8'h80, 1'h1);
            acc1 += inc1;
            acc2 += inc2;
        end
    endtask

    initial begin
        repeat (60000) @(posedge aclk);
        num_errors++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h56fc0803));
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) begin
            rd(offs[i], d, r);
            chk(d, rsts[i]);
        end
        wr(8'h40, 32'h1234_5678, r);
        chk(r, `LTS_RESP_SLVERR);
        rd(8'h40, d, r);
        chk(r, `LTS_RESP_SLVERR);
        chk(d, 32'h0000_0000);
        wr(`LTS_OFF_STATUS, 32'hFFFF_FFFF, r);
        chk(r, `LTS_RESP_OKAY);
        // extremes first, then random tones that stay in force
        for (int i = 0; i < 8; i++) begin
            inc2 = (i < 2) ? 24'h00_0000 : (i < 4) ? 24'hFF_FFFF : (i < 6) ?
                24'(`LTS_INC_MIN + i - 5) : 24'($urandom_range(`LTS_INC_MAX, `LTS_INC_MIN));
            wr(i[0] ? `LTS_OFF_FREQ2 : `LTS_OFF_FREQ1, {8'h00, inc2}, r);
            rd(i[0] ? `LTS_OFF_FREQ2 : `LTS_OFF_FREQ1, d, r);
            chk(d, {8'h00, clamp(inc2)});
            if (i == 6) inc1 = clamp(inc2);
        end
        lv1 = 8'($urandom);
        lv2 = 8'($urandom_range(255, 64));
        wr(`LTS_OFF_LEVEL1, {24'h00_0000, lv1}, r);
        wr(`LTS_OFF_LEVEL2, {24'h00_0000, lv2}, r);
        // host gives both generators square tones, no gating
        wr(`LTS_OFF_CTRL, 32'h0000_000B, r);
        take(30, 0);
        hold <= 1'h1;
        repeat (300) @(posedge aclk);
        rd(`LTS_OFF_STATUS, d, r);
        chk({d[27], out_valid}, 2'h3);
        hold <= 1'h0;
        take(20, 0);
        wr(`LTS_OFF_CTRL, 32'h0000_0003, r);
        repeat (200) @(posedge aclk);
        take(lts_sink_model_i.got.size(), 0);
        rd(`LTS_OFF_STATUS, d, r);
        chk(d[25:0], {acc2[23:11], acc1[23:11]});
        chk({d[26], gate_out}, {2{acc2[23]}});
        rd(`LTS_OFF_SAMPLE, d, r);
        chk(d, {16'h0000, last_p});
        inc1 = 24'($urandom_range(`LTS_INC_MAX, `LTS_INC_MIN));
        wr(`LTS_OFF_FREQ1, {8'h00, inc1}, r);
        rd(`LTS_OFF_STATUS, d, r);
        chk(d[12:0], acc1[23:11]);
        // sine on one, gated square on the other
        sq1 = 1'h0;
        wr(`LTS_OFF_CTRL, 32'h0000_000E, r);
        take(4, 3);
        take(20, 1);
        chk(gate_out, 1'h0);
        pin <= 1'h1;
        take(4, 3);
        take(20, 2);
        chk(gate_out, 1'h1);
        rd(`LTS_OFF_CTRL, d, r);
        chk(d, 32'h0000_000E);
        complete_run();
    end
endmodule

`default_nettype wire
